/* pkg/irq_pin_defs.svh */
// constants for the interrupt pin configuration and latching block
// assumes a 32-bit classic wishbone slave with byte addresses on adr_i
`ifndef IRQ_PIN_DEFS_SVH
`define IRQ_PIN_DEFS_SVH
`define ADR_W          8
`define ADR_PIN_CTRL   8'h00
`define ADR_DATA_MAP   8'h04
`define ADR_FEAT_MAP_A 8'h08
`define ADR_FEAT_MAP_B 8'h0C
`define ADR_STATUS_0   8'h10
`define ADR_STATUS_1   8'h14
`define ADR_EV_STATUS  8'h18
`define ADR_EV_MASK    8'h1C
`define ADR_PIN_STATE  8'h20
`define CTL_W          11
`define CTL_A_LSB      0
`define CTL_B_LSB      4
`define CTL_DRV        0
`define CTL_OD         1
`define CTL_POL        2
`define CTL_RCV        3
`define CTL_LATCH      8
`define CTL_TAG_A      9
`define CTL_TAG_B      10
`define CTL_RESET      11'h000
`define FEAT_W         8
`define DATA_W         5
`define DMAP_W         13
`define DMAP_B_LSB     8
`define ST1_AUX        4
`define EV_W           4
`define CLK_PERIOD_NS  50
`define AUX_HOLD_NS    156250
`define AUX_HOLD_CYC   (`AUX_HOLD_NS / `CLK_PERIOD_NS)
`define AUX_CNT_W      12
`endif

/* pkg/irq_pin_pkg.sv */
// state types for the interrupt pin configuration block
// assumes irq_pin_defs.svh is reachable on the include path
`include "irq_pin_defs.svh"
package irq_pin_pkg;
	typedef struct packed {
		logic                  ack;
		logic [31:0]           rdata;
		logic [`CTL_W-1:0]     ctrl;
		logic [`DMAP_W-1:0]    dmap;
		logic [`FEAT_W-1:0]    fmap_a;
		logic [`FEAT_W-1:0]    fmap_b;
		logic [`FEAT_W-1:0]    st0;
		logic [`DATA_W-1:0]    st1;
		logic [`EV_W-1:0]      ev;
		logic [`EV_W-1:0]      mask;
		logic                  irq;
		logic [`AUX_CNT_W-1:0] aux_cnt;
		logic [1:0]            act_prev;
		logic [1:0]            tag_prev;
	} core_s;

	typedef struct packed {
		logic out;
		logic oe;
		logic tag;
		logic seen_prev;
	} drv_s;

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} sync_s;
endpackage

/* rtl/pin_sync.sv */
// two-flop synchroniser for the two interrupt pin inputs
// assumes pin levels are asynchronous to clk_i
`timescale 1ns/10ps
module pin_sync
	import irq_pin_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] pin_i,
	output logic      [1:0] pin_o
);
	sync_s s_reg;
	sync_s s_next;

	always_comb begin
		s_next.meta = pin_i;
		s_next.sync = s_reg.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_o = s_reg.sync;
endmodule

/* rtl/pin_driver.sv */
// one interrupt pin: output driver, feedback and fifo tag detection
// assumes pin_sync_i is already synchronised to clk_i
`timescale 1ns/10ps
module pin_driver
	import irq_pin_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic active_i,
	input  wire logic drive_on_i,
	input  wire logic open_drain_sel_i,
	input  wire logic polarity_i,
	input  wire logic receive_on_i,
	input  wire logic tag_trigger_type_i,
	input  wire logic pin_sync_i,
	output logic      pin_out_o,
	output logic      pin_oe_o,
	output logic      tag_o
);
	drv_s s_reg;
	drv_s s_next;
	logic level;
	logic seen;

	always_comb begin
		level = ~(active_i ^ polarity_i);
		// own output wins so the tag never races the pad delay
		if (receive_on_i && drive_on_i) begin
			seen = active_i;
		end else begin
			seen = receive_on_i && (pin_sync_i == polarity_i);
		end
		s_next.out = open_drain_sel_i ? 1'b0 : level;
		s_next.oe = drive_on_i && (!open_drain_sel_i || !level);
		s_next.seen_prev = seen;
		s_next.tag = tag_trigger_type_i ? (seen && !s_reg.seen_prev) : seen;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_out_o = s_reg.out;
	assign pin_oe_o = s_reg.oe;
	assign tag_o = s_reg.tag;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	no_receive_a: assert property (!receive_on_i |=> !tag_o)
		else $error("tag seen with input disabled");
	loop_back_a: assert property (receive_on_i && drive_on_i && !tag_trigger_type_i
		|=> tag_o == $past(active_i))
		else $error("tag does not follow own output");
endmodule

/* rtl/irq_pin_latch.sv */
// interrupt pin configuration, mapping and latching with wishbone registers
// assumes interrupt conditions arrive as levels on clk_i, aux ready as a
// pulse, and the pads resolve out/oe pairs outside this module
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
module irq_pin_latch
	import irq_pin_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [`ADR_W-1:0]   adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	input  wire logic [`FEAT_W-1:0]  feat_cond_i,
	input  wire logic [`DATA_W-2:0]  data_cond_i,
	input  wire logic                aux_drdy_i,
	input  wire logic                irq_line_a_i,
	input  wire logic                irq_line_b_i,
	output logic                     irq_line_a_o,
	output logic                     irq_line_a_oe_o,
	output logic                     irq_line_b_o,
	output logic                     irq_line_b_oe_o,
	output logic                     tag_a_o,
	output logic                     tag_b_o,
	output logic                     irq_o
);
	localparam int AUX_HOLD = `AUX_HOLD_CYC;
	localparam logic [`AUX_CNT_W-1:0] AUX_LOAD = `AUX_CNT_W'(AUX_HOLD - 1);

	core_s s_reg;
	core_s s_next;

	logic [1:0]             pin_sync;
	logic                   take;
	logic                   rd_st0;
	logic                   rd_st1;
	logic                   latch_mode;
	logic                   aux_level;
	logic [`DATA_W-1:0]     data_eff;
	logic [`DATA_W-1:0]     dmap_a;
	logic [`DATA_W-1:0]     dmap_b;
	logic [`FEAT_W-1:0]     feat_src;
	logic [`DATA_W-1:0]     data_src;
	logic                   act_a;
	logic                   act_b;
	logic [`EV_W-1:0]       ev_set;
	logic [31:0]            wr_word;
	logic [3:0]             ctl_a;
	logic [3:0]             ctl_b;

	// byte-lane merge of a write into a register image
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// nibble of pin controls for one pin
	function automatic logic [3:0] pin_ctl(input logic [`CTL_W-1:0] c,
		input logic pin_b);
		return pin_b ? c[`CTL_B_LSB +: 4] : c[`CTL_A_LSB +: 4];
	endfunction

	// any source enabled by its map bit
	function automatic logic routed(input logic [`FEAT_W-1:0] f,
		input logic [`FEAT_W-1:0] fm, input logic [`DATA_W-1:0] d,
		input logic [`DATA_W-1:0] dm);
		return |(f & fm) || |(d & dm);
	endfunction

	function automatic logic [31:0] read_mux(input logic [`ADR_W-1:0] a,
		input core_s s, input logic [1:0] ps, input logic [1:0] act);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			`ADR_PIN_CTRL:   r = 32'(s.ctrl);
			`ADR_DATA_MAP:   r = 32'(s.dmap);
			`ADR_FEAT_MAP_A: r = 32'(s.fmap_a);
			`ADR_FEAT_MAP_B: r = 32'(s.fmap_b);
			`ADR_STATUS_0:   r = 32'(s.st0);
			`ADR_STATUS_1:   r = 32'(s.st1);
			`ADR_EV_STATUS:  r = 32'(s.ev);
			`ADR_EV_MASK:    r = 32'(s.mask);
			`ADR_PIN_STATE:  r = 32'({ps, act});
			default:         r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign take = cyc_i && stb_i && !s_reg.ack;
	assign rd_st0 = take && !we_i && (adr_i == `ADR_STATUS_0);
	assign rd_st1 = take && !we_i && (adr_i == `ADR_STATUS_1);
	assign latch_mode = s_reg.ctrl[`CTL_LATCH];
	assign wr_word = merge(32'h0000_0000, dat_i, sel_i);
	assign ctl_a = pin_ctl(s_reg.ctrl, 1'b0);
	assign ctl_b = pin_ctl(s_reg.ctrl, 1'b1);

	always_comb begin
		// latched mode keeps the raw pulse; the status bit holds it
		aux_level = aux_drdy_i || (!latch_mode && s_reg.aux_cnt != '0);
		data_eff = {aux_level, data_cond_i};
		dmap_a = s_reg.dmap[`DATA_W-1:0];
		dmap_b = s_reg.dmap[`DMAP_B_LSB +: `DATA_W];
		if (latch_mode) begin
			feat_src = s_reg.st0;
			data_src = s_reg.st1;
		end else begin
			feat_src = feat_cond_i;
			data_src = data_eff;
		end
		act_a = routed(feat_src, s_reg.fmap_a, data_src, dmap_a);
		act_b = routed(feat_src, s_reg.fmap_b, data_src, dmap_b);
		ev_set = {tag_b_o && !s_reg.tag_prev[1], tag_a_o && !s_reg.tag_prev[0],
			act_b && !s_reg.act_prev[1], act_a && !s_reg.act_prev[0]};
	end

	always_comb begin
		s_next = s_reg;
		s_next.ack = take;
		s_next.act_prev = {act_b, act_a};
		s_next.tag_prev = {tag_b_o, tag_a_o};
		if (aux_drdy_i) begin
			s_next.aux_cnt = AUX_LOAD;
		end else if (s_reg.aux_cnt != '0) begin
			s_next.aux_cnt = s_reg.aux_cnt - `AUX_CNT_W'(1);
		end
		// a read clears; a condition still true sets again in the same edge
		s_next.st0 = (rd_st0 ? '0 : s_reg.st0) | feat_cond_i;
		s_next.st1 = (rd_st1 ? '0 : s_reg.st1) | data_eff;
		s_next.ev = s_reg.ev | ev_set;
		if (take && !we_i) begin
			s_next.rdata = read_mux(adr_i, s_reg, pin_sync, {act_b, act_a});
		end
		if (take && we_i) begin
			unique case (adr_i)
				`ADR_PIN_CTRL:   s_next.ctrl =
					`CTL_W'(merge(32'(s_reg.ctrl), dat_i, sel_i));
				`ADR_DATA_MAP:   s_next.dmap =
					`DMAP_W'(merge(32'(s_reg.dmap), dat_i, sel_i));
				`ADR_FEAT_MAP_A: s_next.fmap_a =
					`FEAT_W'(merge(32'(s_reg.fmap_a), dat_i, sel_i));
				`ADR_FEAT_MAP_B: s_next.fmap_b =
					`FEAT_W'(merge(32'(s_reg.fmap_b), dat_i, sel_i));
				`ADR_EV_STATUS:  s_next.ev =
					(s_reg.ev & ~wr_word[`EV_W-1:0]) | ev_set;
				`ADR_EV_MASK:    s_next.mask =
					`EV_W'(merge(32'(s_reg.mask), dat_i, sel_i));
				default:         s_next.ctrl = s_reg.ctrl;
			endcase
		end
		s_next.irq = |(s_next.ev & s_next.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.ctrl <= `CTL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	pin_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i ({irq_line_b_i, irq_line_a_i}),
		.pin_o (pin_sync)
	);

	pin_driver u_pin_a (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.active_i           (act_a),
		.drive_on_i         (ctl_a[`CTL_DRV]),
		.open_drain_sel_i   (ctl_a[`CTL_OD]),
		.polarity_i         (ctl_a[`CTL_POL]),
		.receive_on_i       (ctl_a[`CTL_RCV]),
		.tag_trigger_type_i (s_reg.ctrl[`CTL_TAG_A]),
		.pin_sync_i         (pin_sync[0]),
		.pin_out_o          (irq_line_a_o),
		.pin_oe_o           (irq_line_a_oe_o),
		.tag_o              (tag_a_o)
	);

	pin_driver u_pin_b (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.active_i           (act_b),
		.drive_on_i         (ctl_b[`CTL_DRV]),
		.open_drain_sel_i   (ctl_b[`CTL_OD]),
		.polarity_i         (ctl_b[`CTL_POL]),
		.receive_on_i       (ctl_b[`CTL_RCV]),
		.tag_trigger_type_i (s_reg.ctrl[`CTL_TAG_B]),
		.pin_sync_i         (pin_sync[1]),
		.pin_out_o          (irq_line_b_o),
		.pin_oe_o           (irq_line_b_oe_o),
		.tag_o              (tag_b_o)
	);

	assign dat_o = s_reg.rdata;
	assign ack_o = s_reg.ack;
	assign irq_o = s_reg.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// pin outputs are registered, so pin checks look one edge ahead
	drive_gate_a: assert property (
		!ctl_a[`CTL_DRV] |=> !irq_line_a_oe_o)
		else $error("pin a driven while disabled");

	drive_gate_b_a: assert property (
		!ctl_b[`CTL_DRV] |=> !irq_line_b_oe_o)
		else $error("pin b driven while disabled");

	od_low_a: assert property (
		ctl_a[`CTL_OD] |=> !irq_line_a_o)
		else $error("open-drain pin a driven high");

	od_low_b_a: assert property (
		ctl_b[`CTL_OD] |=> !irq_line_b_o)
		else $error("open-drain pin b driven high");

	push_pull_a: assert property (
		ctl_a[`CTL_DRV] && !ctl_a[`CTL_OD] |=> irq_line_a_oe_o)
		else $error("push-pull pin a not driven");

	polarity_out_a: assert property (
		ctl_a[`CTL_DRV] && !ctl_a[`CTL_OD]
		|=> irq_line_a_o == $past(act_a == ctl_a[`CTL_POL]))
		else $error("pin a level does not match polarity");

	polarity_b_a: assert property (
		ctl_b[`CTL_DRV] && !ctl_b[`CTL_OD]
		|=> irq_line_b_o == $past(act_b == ctl_b[`CTL_POL]))
		else $error("pin b level does not match polarity");

	float_idle_a: assert property (
		ctl_b[`CTL_OD] && act_b == ctl_b[`CTL_POL]
		|=> !irq_line_b_oe_o)
		else $error("open-drain pin b driven while inactive");

	latched_idle_a: assert property (
		latch_mode && s_reg.st0 == '0 && s_reg.st1 == '0
		|-> !act_a && !act_b)
		else $error("latched pin active with status clear");

	read_clear_a: assert property (
		rd_st1 |=> s_reg.st1 == $past(data_eff))
		else $error("status one not cleared by read");

	feat_clear_a: assert property (
		rd_st0 |=> s_reg.st0 == $past(feat_cond_i))
		else $error("status zero not cleared by read");

	reassert_feat_a: assert property (
		rd_st0 && feat_cond_i != '0
		|=> s_reg.st0 == $past(feat_cond_i))
		else $error("feature status not set again");

	nonlatch_drop_a: assert property (
		!latch_mode && feat_cond_i == '0 && data_eff == '0
		|-> !act_a && !act_b)
		else $error("pin active without condition");

	sticky_hold_a: assert property (
		!rd_st0 |=> (s_reg.st0 & $past(s_reg.st0)) == $past(s_reg.st0))
		else $error("feature status lost without read");

	sticky_data_a: assert property (
		!rd_st1 |=> (s_reg.st1 & $past(s_reg.st1)) == $past(s_reg.st1))
		else $error("data status lost without read");

	unmapped_a: assert property (
		s_reg.fmap_b == '0 && dmap_b == '0 |-> !act_b)
		else $error("unmapped interrupt on pin b");

	unrouted_a: assert property (
		s_reg.fmap_a == '0 && dmap_a == '0 |-> !act_a)
		else $error("unmapped interrupt on pin a");

	feat_status_a: assert property (
		feat_cond_i != '0
		|=> (s_reg.st0 & $past(feat_cond_i)) == $past(feat_cond_i))
		else $error("feature not reported in status zero");

	data_status_a: assert property (
		data_eff != '0
		|=> (s_reg.st1 & $past(data_eff)) == $past(data_eff))
		else $error("data event not reported in status one");

	aux_hold_a: assert property (
		aux_drdy_i |=> s_reg.aux_cnt == AUX_LOAD)
		else $error("aux hold not loaded");

	aux_expire_a: assert property (
		!latch_mode && !aux_drdy_i && s_reg.aux_cnt == `AUX_CNT_W'(1)
		|=> !aux_drdy_i |-> !aux_level)
		else $error("aux ready held too long");

	bus_ack_a: assert property (
		take |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle");

	// a new event must survive a write-one clear in the same cycle
	ev_set_wins_a: assert property (
		ev_set != '0 |=> (s_reg.ev & $past(ev_set)) == $past(ev_set))
		else $error("event lost to a clear");

	irq_mask_a: assert property (
		s_reg.mask == '0 && !take |=> !irq_o)
		else $error("interrupt raised while masked");

	latched_reassert_c: cover property (latch_mode && rd_st1 && data_eff != '0);
	aux_expire_c: cover property (!latch_mode && s_reg.aux_cnt == `AUX_CNT_W'(1));
	tag_edge_c: cover property (s_reg.ctrl[`CTL_TAG_A] && tag_a_o);
	irq_raise_c: cover property (!irq_o ##1 irq_o);
	split_pins_c: cover property (act_a && act_b);
endmodule

/* test/host_irq_pins.sv */
// host side of the two interrupt lines: pad resolution with pull-ups
// assumes the bench may drive a line itself only while the design does not
`timescale 1ns/10ps
module host_irq_pins (
	input  wire logic       a_out_i,
	input  wire logic       a_oe_i,
	input  wire logic       b_out_i,
	input  wire logic       b_oe_i,
	input  wire logic [1:0] ext_oe_i,
	input  wire logic [1:0] ext_val_i,
	output logic      [1:0] level_o
);
	// undriven lines sit at the pull-up, so a floating pin reads high
	assign level_o[0] = a_oe_i ? a_out_i : ext_oe_i[0] ? ext_val_i[0] : 1'b1;
	assign level_o[1] = b_oe_i ? b_out_i : ext_oe_i[1] ? ext_val_i[1] : 1'b1;
endmodule

/* test/test_irq_pin_latch.sv */
// bench for irq_pin_latch: wishbone tasks, pin, latch, tag and aux tests
// assumes host_irq_pins resolves both pads with pull-ups
`timescale 1ns/10ps
`include "irq_pin_defs.svh"
module test_irq_pin_latch;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              cyc_i = 1'b0;
	logic              stb_i = 1'b0;
	logic              we_i = 1'b0;
	logic [`ADR_W-1:0] adr_i = '0;
	logic [3:0]        sel_i = 4'hF;
	logic [31:0]       dat_i = '0;
	logic [31:0]       dat_o;
	logic              ack_o;
	logic [7:0]        feat_cond_i = 8'h00;
	logic [3:0]        data_cond_i = 4'h0;
	logic              aux_drdy_i = 1'b0;
	logic              a_out, a_oe, b_out, b_oe, tag_a_o, tag_b_o, irq_o;
	logic [1:0]        ext_oe = 2'b00;
	logic [1:0]        ext_val = 2'b00;
	logic [1:0]        pad;
	logic [31:0]       sink;
	int                fails = 0;
	int                compares = 0;
	int                cyc_cnt = 0;
	int                pulses;

	irq_pin_latch irq_pin_latch_i (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.feat_cond_i(feat_cond_i), .data_cond_i(data_cond_i),
		.aux_drdy_i(aux_drdy_i), .irq_line_a_i(pad[0]),
		.irq_line_b_i(pad[1]), .irq_line_a_o(a_out),
		.irq_line_a_oe_o(a_oe), .irq_line_b_o(b_out),
		.irq_line_b_oe_o(b_oe), .tag_a_o(tag_a_o), .tag_b_o(tag_b_o),
		.irq_o(irq_o));
	host_irq_pins host_irq_pins_i (.a_out_i(a_out), .a_oe_i(a_oe),
		.b_out_i(b_out), .b_oe_i(b_oe), .ext_oe_i(ext_oe),
		.ext_val_i(ext_val), .level_o(pad));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task test_done;
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one classic cycle; ack is waited for, never assumed
	task wb(input logic w, input logic [`ADR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task wr(input logic [`ADR_W-1:0] a, input logic [31:0] d);
		wb(1'b1, a, d, sink);
	endtask

	task rd(input logic [`ADR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			fails++;
			test_done;
		end
	end

	initial begin
		tick(4);
		rst_i <= 1'b0;
		rd(`ADR_PIN_CTRL, 32'h0);
		rd(`ADR_DATA_MAP, 32'h0);
		rd(8'h24, 32'h0);
		chk_bit(a_oe, 1'b0);
		chk_bit(b_oe, 1'b0);
		$display("test reset done");
		// feature 0 goes to pin a, push-pull active high; pin b unmapped
		wr(`ADR_EV_MASK, 32'h1);
		wr(`ADR_PIN_CTRL, 32'h5);
		wr(`ADR_FEAT_MAP_A, 32'h1);
		feat_cond_i <= 8'h01;
		tick(3);
		chk_bit(pad[0], 1'b1);
		chk_bit(a_oe, 1'b1);
		feat_cond_i <= 8'h00;
		tick(3);
		chk_bit(pad[0], 1'b0);
		rd(`ADR_STATUS_0, 32'h1);
		rd(`ADR_STATUS_0, 32'h0);
		chk_bit(irq_o, 1'b1);
		wr(`ADR_EV_STATUS, 32'h1);
		tick(2);
		chk_bit(irq_o, 1'b0);
		feat_cond_i <= 8'h01;
		tick(3);
		wr(`ADR_FEAT_MAP_A, 32'h0);
		tick(3);
		chk_bit(pad[0], 1'b0);
		feat_cond_i <= 8'h00;
		wr(`ADR_EV_STATUS, 32'hF);
		$display("test non-latched done");
		// pin b open drain, active low, latched
		wr(`ADR_PIN_CTRL, 32'h130);
		wr(`ADR_DATA_MAP, 32'h100);
		data_cond_i <= 4'h1;
		tick(1);
		data_cond_i <= 4'h0;
		tick(6);
		chk_bit(pad[1], 1'b0);
		chk_bit(b_oe, 1'b1);
		chk_bit(irq_o, 1'b0);
		rd(`ADR_STATUS_1, 32'h1);
		tick(3);
		chk_bit(pad[1], 1'b1);
		chk_bit(b_oe, 1'b0);
		data_cond_i <= 4'h1;
		tick(3);
		rd(`ADR_STATUS_1, 32'h1);
		tick(3);
		chk_bit(pad[1], 1'b0);
		data_cond_i <= 4'h0;
		rd(`ADR_STATUS_1, 32'h1);
		tick(3);
		chk_bit(pad[1], 1'b1);
		$display("test latched done");
		wr(`ADR_DATA_MAP, 32'h0);
		wr(`ADR_PIN_CTRL, 32'h8);
		ext_oe <= 2'b01;
		tick(5);
		chk_bit(tag_a_o, 1'b1);
		ext_oe <= 2'b00;
		tick(5);
		chk_bit(tag_a_o, 1'b0);
		wr(`ADR_PIN_CTRL, 32'h208);
		ext_oe <= 2'b01;
		pulses = 0;
		repeat (8) begin
			tick(1);
			if (tag_a_o === 1'b1) pulses++;
		end
		chk(pulses, 32'h1);
		ext_oe <= 2'b00;
		wr(`ADR_PIN_CTRL, 32'h80);
		ext_oe <= 2'b10;
		tick(5);
		chk_bit(tag_b_o, 1'b1);
		ext_oe <= 2'b00;
		tick(5);
		chk_bit(tag_b_o, 1'b0);
		rd(`ADR_PIN_STATE, 32'hC);
		wr(`ADR_PIN_CTRL, 32'hD);
		wr(`ADR_FEAT_MAP_A, 32'h1);
		feat_cond_i <= 8'h01;
		tick(5);
		chk_bit(tag_a_o, 1'b1);
		feat_cond_i <= 8'h00;
		tick(5);
		chk_bit(tag_a_o, 1'b0);
		$display("test tag done");
		// aux hold is fixed at 3125 cycles, no shorter parameter
		wr(`ADR_PIN_CTRL, 32'h5);
		wr(`ADR_FEAT_MAP_A, 32'h0);
		wr(`ADR_DATA_MAP, 32'h10);
		aux_drdy_i <= 1'b1;
		tick(1);
		aux_drdy_i <= 1'b0;
		tick(3000);
		chk_bit(pad[0], 1'b1);
		tick(200);
		chk_bit(pad[0], 1'b0);
		rd(`ADR_STATUS_1, 32'h10);
		$display("test aux done");
		test_done;
	end
endmodule
